// ==== pc_io_channel_bus.sv ====
`default_nettype none
module pc_io_channel_bus (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic osc_src_clk_i,
  input wire logic power_low_i,
  input wire pc_chan_pkg::cpu_req_t cpu_req_i,
  output logic cpu_ack_o,
  output logic cpu_done_o,
  output logic [7:0] cpu_rdata_o,
  input wire pc_chan_pkg::dma_req_t dma_req_i,
  output logic dma_ack_o,
  output logic dma_done_o,
  input wire logic chan_rdy_i,
  input wire logic channel_error_line_n_i,
  input wire logic [5:0] irq_req_i,
  input wire logic nmi_ack_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic [19:0] addr_o,
  output logic ale_o,
  output logic aen_o,
  output pc_chan_pkg::bus_cmd_t cmd_n_o,
  output logic [2:0] dack_n_o,
  output logic tc_o,
  output logic refresh_cycle_flag_n_o,
  output logic bus_clk_o,
  output logic osc_o,
  output logic bus_reset_out_o,
  output logic irq_pending_o,
  output logic [2:0] irq_level_o,
  output logic nmi_o,
  output logic nmi_enabled_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: everything from the connector passes two flops
  localparam int SYNC_W = 17;
  logic [SYNC_W-1:0] pins_q1;
  logic [SYNC_W-1:0] pins_q2;
  logic rdy_s;
  logic chk_n_s;
  logic pwr_low_s;
  logic [5:0] irq_s;
  logic [7:0] data_s;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pins_q1 <= 17'h1c000;
      pins_q2 <= 17'h1c000;
    end else begin
      pins_q1 <= {chan_rdy_i, channel_error_line_n_i, power_low_i, irq_req_i, data_i};
      pins_q2 <= pins_q1;
    end
  end
  assign {rdy_s, chk_n_s, pwr_low_s, irq_s, data_s} = pins_q2;

  ////////////////////////////////////////////////////////////////////////////
  // bus clock: integer divide of the system clock, high for one third
  logic [3:0] div_cnt;
  logic rise_tick;
  logic fall_tick;

  assign rise_tick = (div_cnt == pc_chan_pkg::BUS_DIV - 4'h1);
  assign fall_tick = (div_cnt == pc_chan_pkg::BUS_HIGH - 4'h1);

  // 125/15 gives 8.33 MHz; the divide is the quotient of 125/8 rounded down
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_cnt <= 4'h0;
      bus_clk_o <= 1'b0;
    end else begin
      div_cnt <= rise_tick ? 4'h0 : div_cnt + 4'h1;
      if (rise_tick) begin
        bus_clk_o <= 1'b1;
      end else if (fall_tick) begin
        bus_clk_o <= 1'b0;
      end
    end
  end

  chk_clk_duty: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(bus_clk_o) |-> bus_clk_o [*5] ##1 !bus_clk_o)
    else $error("bus clock high phase is not one third");

  ////////////////////////////////////////////////////////////////////////////
  // oscillator line in the link domain: half the source, so exactly 50 percent
  logic osc_rst_q1;
  logic osc_rst_q2;

  // reset level crosses by two flops; no other state is shared
  always_ff @(posedge osc_src_clk_i) begin
    osc_rst_q1 <= sys_rst_i;
    osc_rst_q2 <= osc_rst_q1;
  end

  always_ff @(posedge osc_src_clk_i) begin
    if (osc_rst_q2) begin
      osc_o <= 1'b0;
    end else begin
      osc_o <= !osc_o;
    end
  end

  chk_osc_toggle: assert property (@(posedge osc_src_clk_i) disable iff (osc_rst_q2)
    !osc_o |=> osc_o ##1 !osc_o)
    else $error("oscillator line does not toggle every source edge");

  ////////////////////////////////////////////////////////////////////////////
  // reset drive follows board reset or low voltage, moved on the clock fall
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_reset_out_o <= 1'b1;
    end else if (fall_tick) begin
      bus_reset_out_o <= pwr_low_s;
    end
  end

  chk_reset_edge: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $changed(bus_reset_out_o) |-> $past(fall_tick) && !bus_clk_o)
    else $error("bus reset changed away from the clock fall");

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle engine
  pc_chan_pkg::state_t state;
  logic owner_dma;
  pc_chan_pkg::cpu_req_t creq;
  pc_chan_pkg::dma_req_t dreq;
  logic [2:0] cmd_cnt;
  pc_chan_pkg::bus_cmd_t next_cmd;
  logic [2:0] next_ticks;
  logic [2:0] next_dack_n;
  logic take_dma;
  logic take_cpu;

  assign take_dma = rise_tick && state == pc_chan_pkg::ST_IDLE && dma_req_i.valid;
  assign take_cpu = rise_tick && state == pc_chan_pkg::ST_IDLE && !dma_req_i.valid
                    && cpu_req_i.valid;

  // strobe set for the latched owner; DMA transfers pair a memory and an I/O strobe, refresh uses memory read alone
  always_comb begin
    next_cmd = pc_chan_pkg::CMD_IDLE;
    next_ticks = pc_chan_pkg::CMD_MEM_TICKS;
    if (owner_dma) begin
      if (dreq.refresh) begin
        next_cmd.mem_rd_n = 1'b0;
      end else if (dreq.to_mem) begin
        next_cmd.io_rd_n = 1'b0;
        next_cmd.mem_wr_n = 1'b0;
      end else begin
        next_cmd.mem_rd_n = 1'b0;
        next_cmd.io_wr_n = 1'b0;
      end
    end else begin
      unique case (creq.kind)
        pc_chan_pkg::MEM_RD: next_cmd.mem_rd_n = 1'b0;
        pc_chan_pkg::MEM_WR: next_cmd.mem_wr_n = 1'b0;
        pc_chan_pkg::IO_RD: next_cmd.io_rd_n = 1'b0;
        pc_chan_pkg::IO_WR: next_cmd.io_wr_n = 1'b0;
      endcase
      if (creq.kind == pc_chan_pkg::IO_RD || creq.kind == pc_chan_pkg::IO_WR) begin
        next_ticks = pc_chan_pkg::CMD_IO_TICKS;
      end
    end
  end

  // channel 0 has no acknowledge pin, so it never lowers one
  for (genvar g = 0; g < 3; g++) begin : g_dack
    assign next_dack_n[g] = !(dreq.chan == 2'(g + 1) && !dreq.refresh);
  end

  // one step per bus clock rise; ready is looked at only on that edge
  always_ff @(posedge clk_i) begin
    cpu_ack_o <= 1'b0;
    dma_ack_o <= 1'b0;
    cpu_done_o <= 1'b0;
    dma_done_o <= 1'b0;
    if (sys_rst_i) begin
      state <= pc_chan_pkg::ST_IDLE;
      owner_dma <= 1'b0;
      creq <= '0;
      dreq <= '0;
      cmd_cnt <= 3'h0;
      addr_o <= 20'h00000;
      ale_o <= 1'b0;
      aen_o <= 1'b0;
      cmd_n_o <= pc_chan_pkg::CMD_IDLE;
      dack_n_o <= 3'h7;
      tc_o <= 1'b0;
      refresh_cycle_flag_n_o <= 1'b1;
      data_oe_o <= 1'b0;
      data_o <= 8'h00;
      cpu_rdata_o <= 8'h00;
    end else if (rise_tick) begin
      unique case (state)
        pc_chan_pkg::ST_IDLE: begin
          if (take_dma) begin
            owner_dma <= 1'b1;
            dreq <= dma_req_i;
            addr_o <= dma_req_i.addr;
            aen_o <= 1'b1;
            ale_o <= 1'b1;
            dma_ack_o <= 1'b1;
            state <= pc_chan_pkg::ST_ADDR;
          end else if (take_cpu) begin
            owner_dma <= 1'b0;
            creq <= cpu_req_i;
            addr_o <= cpu_req_i.addr;
            ale_o <= 1'b1;
            cpu_ack_o <= 1'b1;
            state <= pc_chan_pkg::ST_ADDR;
          end
        end
        pc_chan_pkg::ST_ADDR: begin
          // processor address already stands when latch enable falls here
          ale_o <= owner_dma;
          cmd_n_o <= next_cmd;
          cmd_cnt <= next_ticks;
          tc_o <= owner_dma && dreq.last && !dreq.refresh;
          refresh_cycle_flag_n_o <= !(owner_dma && dreq.refresh);
          dack_n_o <= owner_dma ? next_dack_n : 3'h7;
          // the host drives data only for its own writes; DMA data flows between card and memory
          data_oe_o <= !owner_dma && (creq.kind == pc_chan_pkg::MEM_WR
                       || creq.kind == pc_chan_pkg::IO_WR);
          data_o <= creq.wdata;
          state <= pc_chan_pkg::ST_CMD;
        end
        pc_chan_pkg::ST_CMD: begin
          if (cmd_cnt != 3'h0) begin
            cmd_cnt <= cmd_cnt - 3'h1;
          end else if (rdy_s) begin
            cmd_n_o <= pc_chan_pkg::CMD_IDLE;
            tc_o <= 1'b0;
            cpu_rdata_o <= data_s;
            state <= pc_chan_pkg::ST_END;
          end
          // ready low here stretches the strobe by one bus clock
        end
        pc_chan_pkg::ST_END: begin
          aen_o <= 1'b0;
          ale_o <= 1'b0;
          dack_n_o <= 3'h7;
          data_oe_o <= 1'b0;
          refresh_cycle_flag_n_o <= 1'b1;
          cpu_done_o <= !owner_dma;
          dma_done_o <= owner_dma;
          state <= pc_chan_pkg::ST_IDLE;
        end
      endcase
    end
  end

  chk_wait_ready: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state == pc_chan_pkg::ST_CMD && cmd_cnt == 3'h0 && rise_tick && !rdy_s
    |=> state == pc_chan_pkg::ST_CMD && cmd_n_o != pc_chan_pkg::CMD_IDLE)
    else $error("strobe released while ready low");

  chk_strobe_ready: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(cmd_n_o == pc_chan_pkg::CMD_IDLE) |-> $past(rdy_s) && $past(rise_tick))
    else $error("strobe released without ready sampled on a bus clock");

  chk_aen_owner: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    aen_o |-> !data_oe_o && owner_dma)
    else $error("processor side drives the bus during DMA");

  chk_ale_dma: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    aen_o && state != pc_chan_pkg::ST_IDLE |-> ale_o)
    else $error("latch enable dropped inside a DMA cycle");

  chk_addr_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(ale_o) && state != pc_chan_pkg::ST_IDLE
    |-> $stable(addr_o) throughout (state != pc_chan_pkg::ST_IDLE) [*8])
    else $error("address moved while latch enable low");

  chk_dack_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    owner_dma && dreq.chan == 2'h0 |-> dack_n_o == 3'h7)
    else $error("acknowledge shown for channel 0");

  chk_tc_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(tc_o) |-> owner_dma && dreq.last && state == pc_chan_pkg::ST_CMD
    ##[1:300] !tc_o)
    else $error("terminal count without last DMA transfer");

  chk_refresh_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !refresh_cycle_flag_n_o |-> aen_o && cmd_n_o.io_rd_n && cmd_n_o.io_wr_n
    && cmd_n_o.mem_wr_n)
    else $error("refresh flag on a non-refresh cycle");

  chk_io_strobe: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !cmd_n_o.io_wr_n && !aen_o |-> data_oe_o && cmd_n_o.io_rd_n)
    else $error("processor I/O write without driven data");

  ////////////////////////////////////////////////////////////////////////////
  // non-maskable interrupt: enable latch, check filter, pending flag
  logic nmi_wr;
  logic [1:0] chk_cnt;

  assign nmi_wr = take_cpu && cpu_req_i.kind == pc_chan_pkg::IO_WR
                  && cpu_req_i.addr[15:0] == pc_chan_pkg::NMI_REG_ADDR;

  // bit 7 of the written byte sets or clears the enable
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      nmi_enabled_o <= 1'b0;
    end else if (nmi_wr) begin
      nmi_enabled_o <= cpu_req_i.wdata[pc_chan_pkg::NMI_ENABLE_BIT];
    end
  end

  // a one-clock glitch on the check line must not raise the interrupt
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || chk_n_s) begin
      chk_cnt <= 2'h0;
    end else if (rise_tick && chk_cnt != pc_chan_pkg::CHK_MIN_TICKS) begin
      chk_cnt <= chk_cnt + 2'h1;
    end
  end

  // a new check wins over an acknowledge in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      nmi_o <= 1'b0;
    end else if (chk_cnt == pc_chan_pkg::CHK_MIN_TICKS && nmi_enabled_o) begin
      nmi_o <= 1'b1;
    end else if (nmi_ack_i) begin
      nmi_o <= 1'b0;
    end
  end

  chk_nmi_check: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    chk_cnt == pc_chan_pkg::CHK_MIN_TICKS && nmi_enabled_o |=> nmi_o)
    else $error("channel check did not raise the interrupt");

  chk_nmi_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(nmi_o) |-> $past(nmi_enabled_o))
    else $error("interrupt raised while masked");

  ////////////////////////////////////////////////////////////////////////////
  // interrupt levels: lowest line number wins; lines are held by the cards
  localparam logic [2:0] IRQ_LO_DEF = 3'h0;
  logic [2:0] next_level;

  always_comb begin
    next_level = IRQ_LO_DEF;
    for (int i = pc_chan_pkg::IRQ_N - 1; i >= 0; i--) begin
      if (irq_s[i]) begin
        next_level = pc_chan_pkg::IRQ_LO + 3'(i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_pending_o <= 1'b0;
      irq_level_o <= 3'h0;
    end else begin
      irq_pending_o <= |irq_s;
      irq_level_o <= next_level;
    end
  end

  chk_irq_prio: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_s[0] |=> irq_pending_o && irq_level_o == pc_chan_pkg::IRQ_LO)
    else $error("level 2 not given top priority");

endmodule : pc_io_channel_bus
`default_nettype wire

// ==== pc_chan_pkg.sv ====
// Behaviour
// - each bus clock with ready low, once the strobe count has run out, adds one wait state to the cycle.
// - twenty address lines, bit 0 lowest, driven by processor or DMA.
// - address enable high gives DMA the buses; low gives the processor them.
// - address valid at latch-enable fall and held while latch enable low.
// - latch enable stays high throughout DMA cycles.
// - bus clock near 8 MHz with one-third high duty cycle.
// - separate free-running oscillator line with 50 percent duty.
// - channel error held two bus clocks raises a non-maskable interrupt.
// - interrupt levels 2 to 7, level 2 highest; adapter holds until acknowledged.
// - DMA acknowledges only for channels 1 to 3, never channel 0.
// - terminal count pulses when any DMA channel reaches its end.
// - bus reset driven at power-up and low voltage, changing on clock fall.
// - I/O read strobe has device drive data; I/O write strobe has it capture.
// - memory read and write strobes, from processor or DMA.
// - refresh flag marks a bus cycle as memory refresh.
// - I/O write of 80 hex to A0 hex enables the non-maskable interrupt.
`default_nettype none
package pc_chan_pkg;
  localparam int SYS_CLK_HZ = 125_000_000;
  localparam int BUS_CLK_HZ = 8_000_000;
  localparam logic [3:0] BUS_DIV = 4'(SYS_CLK_HZ / BUS_CLK_HZ);
  localparam logic [3:0] BUS_HIGH = BUS_DIV / 4'h3;
  localparam int BUS_PERIOD_NS = 125;
  localparam int CMD_IO_NS = 605;
  localparam int CMD_MEM_NS = 395;
  localparam logic [2:0] CMD_IO_TICKS = 3'((CMD_IO_NS + BUS_PERIOD_NS - 1) / BUS_PERIOD_NS);
  localparam logic [2:0] CMD_MEM_TICKS = 3'((CMD_MEM_NS + BUS_PERIOD_NS - 1) / BUS_PERIOD_NS);
  localparam logic [1:0] CHK_MIN_TICKS = 2'h2;
  localparam logic [15:0] NMI_REG_ADDR = 16'h00a0;
  localparam int NMI_ENABLE_BIT = 7;
  localparam logic [2:0] IRQ_LO = 3'h2;
  localparam int IRQ_N = 6;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  typedef enum logic [1:0] {MEM_RD = 2'h0, MEM_WR = 2'h1, IO_RD = 2'h2, IO_WR = 2'h3} kind_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_ADDR = 4'b0010, ST_CMD = 4'b0100, ST_END = 4'b1000
  } state_t;

  typedef struct packed {
    logic valid;
    kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic to_mem;
    logic refresh;
    logic last;
    logic [ADDR_W-1:0] addr;
  } dma_req_t;

  typedef struct packed {
    logic mem_rd_n;
    logic mem_wr_n;
    logic io_rd_n;
    logic io_wr_n;
  } bus_cmd_t;

  localparam bus_cmd_t CMD_IDLE = 4'hf;
endpackage : pc_chan_pkg
`default_nettype wire

// ==== adapter_card_model.sv ====
`default_nettype none
module adapter_card_model (
  input wire logic clk_i,
  input wire logic [19:0] addr_i,
  input wire logic aen_i,
  input wire pc_chan_pkg::bus_cmd_t cmd_n_i,
  input wire logic [7:0] host_data_i,
  input wire logic host_oe_i,
  input wire logic [7:0] wait_clks_i,
  output logic [7:0] data_o,
  output logic rdy_o,
  output logic [7:0] store_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic io_sel, mem_sel, rd, act;
  logic [7:0] cnt = 8'h00;
  logic [7:0] last = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // full 16-bit I/O and 20-bit memory decode above the board range, gated by address enable
  assign io_sel = !aen_i && addr_i[15:0] == 16'h0300;
  assign mem_sel = !aen_i && addr_i == 20'hc0000;
  assign rd = (io_sel && !cmd_n_i.io_rd_n) || (mem_sel && !cmd_n_i.mem_rd_n);
  assign act = rd || (io_sel && !cmd_n_i.io_wr_n) || (mem_sel && !cmd_n_i.mem_wr_n);
  // not ready as soon as a strobe reaches the selected card; bench keeps waits well under 17 bus clocks
  assign rdy_o = !(act && cnt < wait_clks_i);
  // released bus shows the inverse of the last value so stale data cannot pass
  assign data_o = rd ? store_o : ~last;
  ////////////////////////////////////////////////////////////////////////////////
  // wait counter, bus history and write capture
  always_ff @(posedge clk_i) begin
    cnt <= act ? cnt + 8'h01 : 8'h00;
    last <= data_o;
    if (act && !rd && host_oe_i) store_o <= host_data_i;
  end
endmodule : adapter_card_model
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic osc_src_clk_i = 1'b0;
  logic power_low_i = 1'b1;
  logic channel_error_line_n_i = 1'b1;
  logic nmi_ack_i = 1'b0;
  logic [5:0] irq_req_i = 6'h00;
  logic [7:0] wait_clks = 8'h00;
  pc_chan_pkg::cpu_req_t cpu_req_i = '0;
  pc_chan_pkg::dma_req_t dma_req_i = '0;
  pc_chan_pkg::bus_cmd_t cmd_n_o;
  logic [7:0] card_data, store, data_o, cpu_rdata_o;
  logic [19:0] addr_o;
  logic [2:0] dack_n_o, irq_level_o;
  logic cpu_ack_o, cpu_done_o, dma_ack_o, dma_done_o, data_oe_o, ale_o, aen_o, tc_o;
  logic chan_rdy, refresh_cycle_flag_n_o, bus_clk_o, osc_o, bus_reset_out_o;
  logic irq_pending_o, nmi_o, nmi_enabled_o;
  int errors = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clocks: link clock offset so it keeps no phase with the system clock
  always #4 clk_i = ~clk_i;
  initial begin
    #7;
    forever #15 osc_src_clk_i = ~osc_src_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  pc_io_channel_bus pc_io_channel_bus_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .osc_src_clk_i(osc_src_clk_i),
    .power_low_i(power_low_i), .cpu_req_i(cpu_req_i), .cpu_ack_o(cpu_ack_o),
    .cpu_done_o(cpu_done_o), .cpu_rdata_o(cpu_rdata_o), .dma_req_i(dma_req_i),
    .dma_ack_o(dma_ack_o), .dma_done_o(dma_done_o), .chan_rdy_i(chan_rdy),
    .channel_error_line_n_i(channel_error_line_n_i), .irq_req_i(irq_req_i),
    .nmi_ack_i(nmi_ack_i), .data_i(card_data), .data_o(data_o), .data_oe_o(data_oe_o),
    .addr_o(addr_o), .ale_o(ale_o), .aen_o(aen_o), .cmd_n_o(cmd_n_o),
    .dack_n_o(dack_n_o), .tc_o(tc_o), .refresh_cycle_flag_n_o(refresh_cycle_flag_n_o),
    .bus_clk_o(bus_clk_o), .osc_o(osc_o), .bus_reset_out_o(bus_reset_out_o),
    .irq_pending_o(irq_pending_o), .irq_level_o(irq_level_o), .nmi_o(nmi_o),
    .nmi_enabled_o(nmi_enabled_o));
  adapter_card_model adapter_card_model_inst (
    .clk_i(clk_i), .addr_i(addr_o), .aen_i(aen_o), .cmd_n_i(cmd_n_o),
    .host_data_i(data_o), .host_oe_i(data_oe_o), .wait_clks_i(wait_clks),
    .data_o(card_data), .rdy_o(chan_rdy), .store_o(store));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // bounded wait on a one-clock pulse, sampled mid-cycle
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    if (s !== 1'b1) check("wait_timeout", s, 1'b1);
  endtask : wait_hi
  // request held until ack is seen, then dropped so it is not retaken
  task automatic cpu_cycle(input pc_chan_pkg::kind_t k, input logic [19:0] a,
      input logic [7:0] wd, output int dur);
    int n;
    @(negedge clk_i);
    cpu_req_i = '{1'b1, k, a, wd};
    wait_hi(cpu_ack_o, n);
    cpu_req_i.valid = 1'b0;
    @(negedge clk_i);
    wait_hi(cpu_done_o, dur);
    dur = dur + 1;
    check("cpu_addr", addr_o, a);
  endtask : cpu_cycle
  task automatic dma_cycle(input logic [1:0] ch, input logic tm, input logic rf,
      input logic lst);
    int n;
    @(negedge clk_i);
    dma_req_i = '{1'b1, ch, tm, rf, lst, 20'h01230};
    wait_hi(dma_ack_o, n);
    dma_req_i.valid = 1'b0;
    repeat (30) @(negedge clk_i);
    check("dma_cmd", cmd_n_o, rf ? 4'h7 : (tm ? 4'h9 : 4'h6));
    check("aen", aen_o, 1'b1);
    check("ale", ale_o, 1'b1);
    check("dack", dack_n_o, (ch == 2'h0 || rf) ? 3'h7 : 3'(~(3'h1 << (ch - 2'h1))));
    check("tc", tc_o, lst);
    check("refresh", refresh_cycle_flag_n_o, !rf);
    wait_hi(dma_done_o, n);
    check("dma_done", dma_done_o, 1'b1);
  endtask : dma_cycle
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("idle_cmd", cmd_n_o, pc_chan_pkg::CMD_IDLE);
    check("idle_dack", dack_n_o, 3'h7);
    check("bus_reset", bus_reset_out_o, 1'b1);
    power_low_i = 1'b0;
    repeat (40) @(negedge clk_i);
    check("bus_reset_off", bus_reset_out_o, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_clocks();
    int hi;
    int lo;
    int osc_n;
    logic prev;
    hi = 0;
    lo = 0;
    osc_n = 0;
    @(posedge bus_clk_o);
    @(negedge clk_i);
    while (bus_clk_o === 1'b1 && hi < 20) begin
      @(negedge clk_i);
      hi++;
    end
    while (bus_clk_o === 1'b0 && lo < 20) begin
      @(negedge clk_i);
      lo++;
    end
    check("clk_high", hi, 5);
    check("clk_low", lo, 10);
    prev = osc_o;
    repeat (300) begin
      @(negedge clk_i);
      if (osc_o !== prev) osc_n++;
      prev = osc_o;
    end
    check("osc_edges", osc_n >= 79 && osc_n <= 81, 1'b1);
    $display("test clocks done");
  endtask : t_clocks
  // slow card: the long wait must stretch the read by whole bus clocks
  task automatic t_io();
    int dur;
    cpu_cycle(pc_chan_pkg::IO_WR, 20'h00300, 8'h5a, dur);
    check("io_wr_data", store, 8'h5a);
    check("io_wr_len", dur, 120);
    wait_clks = 8'd142;
    cpu_cycle(pc_chan_pkg::IO_RD, 20'h00300, 8'h00, dur);
    check("io_rd_data", cpu_rdata_o, 8'h5a);
    check("io_rd_len", dur, 180);
    wait_clks = 8'h00;
    cpu_cycle(pc_chan_pkg::MEM_WR, 20'hc0000, 8'ha5, dur);
    check("mem_wr_data", store, 8'ha5);
    cpu_cycle(pc_chan_pkg::MEM_RD, 20'hc0000, 8'h00, dur);
    check("mem_rd_data", cpu_rdata_o, 8'ha5);
    check("mem_rd_len", dur, 105);
    $display("test io done");
  endtask : t_io
  task automatic t_dma();
    for (int ch = 0; ch < 4; ch++) begin
      dma_cycle(2'(ch), ch[0], 1'b0, ch[1]);
    end
    dma_cycle(2'h0, 1'b0, 1'b1, 1'b0);
    $display("test dma done");
  endtask : t_dma
  task automatic t_nmi();
    int dur;
    cpu_cycle(pc_chan_pkg::IO_WR, 20'h000a0, 8'h80, dur);
    check("nmi_en", nmi_enabled_o, 1'b1);
    channel_error_line_n_i = 1'b0;
    repeat (12) @(negedge clk_i);
    channel_error_line_n_i = 1'b1;
    repeat (40) @(negedge clk_i);
    check("nmi_short", nmi_o, 1'b0);
    channel_error_line_n_i = 1'b0;
    repeat (60) @(negedge clk_i);
    channel_error_line_n_i = 1'b1;
    repeat (5) @(negedge clk_i);
    check("nmi_set", nmi_o, 1'b1);
    nmi_ack_i = 1'b1;
    @(negedge clk_i);
    nmi_ack_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("nmi_clr", nmi_o, 1'b0);
    cpu_cycle(pc_chan_pkg::IO_WR, 20'h000a0, 8'h00, dur);
    check("nmi_dis", nmi_enabled_o, 1'b0);
    channel_error_line_n_i = 1'b0;
    repeat (60) @(negedge clk_i);
    channel_error_line_n_i = 1'b1;
    repeat (5) @(negedge clk_i);
    check("nmi_masked", nmi_o, 1'b0);
    $display("test nmi done");
  endtask : t_nmi
  task automatic t_irq();
    logic [5:0] pat [4] = '{6'h28, 6'h01, 6'h20, 6'h00};
    logic [2:0] lvl [4] = '{3'h5, 3'h2, 3'h7, 3'h0};
    for (int i = 0; i < 4; i++) begin
      irq_req_i = pat[i];
      repeat (8) @(negedge clk_i);
      check("irq_level", irq_level_o, lvl[i]);
      check("irq_pending", irq_pending_o, pat[i] != 6'h00);
    end
    $display("test irq done");
  endtask : t_irq
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    t_reset();
    t_clocks();
    t_io();
    t_dma();
    t_nmi();
    t_irq();
    stop_test();
  end
  // watchdog: the tests need well under 10,000 clocks
  initial begin
    #200000;
    errors++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
